// [reset_and_power_control_tb.sv]
// Self-checking testbench for the reset and power control block
`timescale 1ns/1ps
module reset_and_power_control_tb;
    localparam int D = 4;
    localparam logic [7:0] CV [4] = '{8'h2a, 8'h6a, 8'h1a, 8'h08};
    localparam logic EV [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic [31:0] s_axi_rdata, rd;
    logic powerOnLow, extResetN, watchdogTimeout, brownoutLow, scanResetBit;
    logic watchdogEnable = 1'b0, adcConvStart = 1'b0, tapShifting = 1'b0, tdoData = 1'b0;
    rpc_pkg::rpc_fuses_s fuses = '0;
    logic [31:0] wakePinMask = 32'h0000_00f0;
    logic portResetAsync, ioRegReset_q, vectorFetch_q, adcExtendedNext_q;
    logic scanEnabled, tdoOut, tdoOe;
    rpc_pkg::rpc_power_s power_q;
    logic [31:0] inputBufEnable_q;
    int errors = 0;
    int checked = 0;

    rpc_reset_power #(
        .PIN_COUNT(32),
        .STARTUP_CYC(D)
    ) dut (
        .clk(clk),
        .srst(srst),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .powerOnLow(powerOnLow),
        .extResetN(extResetN),
        .watchdogTimeout(watchdogTimeout),
        .watchdogEnable(watchdogEnable),
        .brownoutLow(brownoutLow),
        .scanResetBit(scanResetBit),
        .fuses(fuses),
        .adcConvStart(adcConvStart),
        .wakePinMask(wakePinMask),
        .tapShifting(tapShifting),
        .tdoData(tdoData),
        .portResetAsync(portResetAsync),
        .ioRegReset_q(ioRegReset_q),
        .vectorFetch_q(vectorFetch_q),
        .power_q(power_q),
        .adcExtendedNext_q(adcExtendedNext_q),
        .inputBufEnable_q(inputBufEnable_q),
        .scanEnabled(scanEnabled),
        .tdoOut(tdoOut),
        .tdoOe(tdoOe)
    );
    rpc_source_model src (
        .clk(clk),
        .powerOnLow(powerOnLow),
        .extResetN(extResetN),
        .watchdogTimeout(watchdogTimeout),
        .brownoutLow(brownoutLow),
        .scanResetBit(scanResetBit)
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tmo(input logic ok);
        if (!ok)
        begin
            errors++;
            stop_test();
        end
    endtask

    task automatic axw(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic ta, tw, tb;
        n = 0;
        tb = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb && n < 300)
        begin
            @(negedge clk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid;
            br = s_axi_bresp;
            @(posedge clk);
            if (ta)
                s_axi_awvalid <= 1'b0;
            if (tw)
                s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        tmo(tb);
    endtask

    task automatic axr(input logic [3:0] a);
        int n;
        logic ta, tr;
        n = 0;
        tr = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr && n < 300)
        begin
            @(negedge clk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge clk);
            if (ta)
                s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        tmo(tr);
    endtask

    // Counts cycles until internal reset lets go
    task automatic relWait(input int lo);
        int n;
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (ioRegReset_q && n < 300);
        tmo(!ioRegReset_q);
        chk("release delay", 32'(n >= lo && n <= lo + 3), 32'h1);
        chk("vector fetch", 32'(vectorFetch_q), 32'h1);
    endtask

    task automatic srcCase(input int idx, input int hold, input logic [31:0] cause);
        src.set(idx, 1'b1);
        @(negedge clk);
        if (idx != 3)
            chk("port reset", 32'(portResetAsync), 32'h1);
        repeat (hold) @(posedge clk);
        @(negedge clk);
        chk("internal reset", 32'(ioRegReset_q), 32'h1);
        src.set(idx, 1'b0);
        relWait(D << fuses.clockSelect[1:0]);
        axr(rpc_pkg::ADDR_CAUSE);
        chk("cause flags", rd, cause);
    endtask

    task automatic noReset(input int idx, input int hold);
        src.set(idx, 1'b1);
        @(negedge clk);
        chk("port reset", 32'(portResetAsync), 32'(idx == 1));
        repeat (hold) @(posedge clk);
        @(negedge clk);
        chk("no reset", 32'(ioRegReset_q), 32'h0);
        src.set(idx, 1'b0);
    endtask

    task automatic pwrModes();
        for (int i = 0; i < 8; i++)
        begin
            if (i == 4 || i == 5)
                continue;
            axw(rpc_pkg::ADDR_POWER_CTRL, 32'h28 | 32'(i));
            fuses.brownoutLevel <= i[0];
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk("comparator", 32'(power_q.compEnable), 32'(i < 2));
            chk("buffers", inputBufEnable_q, (i < 2) ? 32'hffff_ffff : wakePinMask);
            chk("main clock", 32'(power_q.mainClockRun), 32'(i != 2 && i != 3));
            chk("watchdog run", 32'(power_q.watchdogRun), 32'h1);
            chk("brownout on", 32'(power_q.brownoutDetEnable), 32'h1);
            chk("brownout level", 32'(power_q.brownoutLevelHigh), 32'(i[0]));
            chk("reference", 32'(power_q.refEnable), 32'h1);
        end
    endtask

    task automatic refCases();
        fuses.brownoutEnable <= 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            axw(rpc_pkg::ADDR_POWER_CTRL, 32'(CV[i]));
            repeat (2) @(negedge clk);
            chk("reference", 32'(power_q.refEnable), 32'(EV[i]));
            chk("converter", 32'(power_q.adcEnable), 32'(i == 2));
        end
        @(posedge clk);
        adcConvStart <= 1'b1;
        @(posedge clk);
        adcConvStart <= 1'b0;
        @(negedge clk);
        chk("extended", 32'(adcExtendedNext_q), 32'h0);
        axw(rpc_pkg::ADDR_POWER_CTRL, 32'h00);
        axw(rpc_pkg::ADDR_POWER_CTRL, 32'h10);
        @(negedge clk);
        chk("extended", 32'(adcExtendedNext_q), 32'h1);
    endtask

    task automatic scanCases();
        axw(rpc_pkg::ADDR_CAUSE, 32'h01);
        fuses.scanPortEnable <= 1'b1;
        fuses.debugEnable <= 1'b1;
        axw(rpc_pkg::ADDR_POWER_CTRL, 32'h0a);
        repeat (2) @(negedge clk);
        chk("main clock", 32'(power_q.mainClockRun), 32'h1);
        chk("tdo float", 32'({scanEnabled, tdoOe}), 32'h2);
        @(posedge clk);
        tapShifting <= 1'b1;
        tdoData <= 1'b1;
        @(negedge clk);
        chk("tdo drive", 32'({tdoOe, tdoOut}), 32'h3);
        axw(rpc_pkg::ADDR_CAUSE, 32'h81);
        @(negedge clk);
        chk("scan off", 32'({scanEnabled, tdoOe}), 32'h0);
        axw(rpc_pkg::ADDR_CAUSE, 32'h01);
        fuses.scanPortEnable <= 1'b0;
        @(negedge clk);
        chk("scan fuse", 32'(scanEnabled), 32'h0);
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        relWait(D);
        axr(rpc_pkg::ADDR_CAUSE);
        chk("cause reset", rd, 32'h01);
        chk("read resp", 32'(rr), 32'(rpc_pkg::RESP_OKAY));
        axr(rpc_pkg::ADDR_STATUS);
        chk("status", rd & 32'h101, 32'h100);
        axr(4'hc);
        chk("unmapped resp", 32'(rr), 32'(rpc_pkg::RESP_SLVERR));
        chk("unmapped data", rd, 32'h0);
        axw(4'hc, 32'h0);
        chk("unmapped write", 32'(br), 32'(rpc_pkg::RESP_SLVERR));
        axw(rpc_pkg::ADDR_CAUSE, 32'h00);
        chk("write resp", 32'(br), 32'(rpc_pkg::RESP_OKAY));
        fuses.brownoutEnable <= 1'b1;
        noReset(1, 10);
        noReset(3, 3);
        watchdogEnable <= 1'b1;
        srcCase(1, 80, 32'h02);
        // Pulse is registered, internal reset follows one edge later
        srcCase(3, 2, 32'h0a);
        srcCase(2, 3, 32'h0e);
        srcCase(4, 3, 32'h1e);
        srcCase(0, 3, 32'h01);
        fuses.clockSelect <= 4'h1;
        src.set(2, 1'b1);
        src.set(2, 1'b0);
        repeat (3) @(posedge clk);
        src.set(2, 1'b1);
        src.set(2, 1'b0);
        relWait(2 * D);
        @(posedge clk);
        fuses.clockSelect <= 4'h0;
        pwrModes();
        refCases();
        scanCases();
        stop_test();
    end
endmodule // reset_and_power_control_tb

// [rpc_pkg.sv]
// Constants and carrier types for the reset and power control block
package rpc_pkg;
    localparam int CLK_PERIOD_NS = 20;
    localparam int PIN_MIN_PULSE_NS = 1500;
    localparam int PIN_MIN_CYC = (PIN_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STARTUP_UNIT_NS = 4000;
    localparam int STARTUP_UNIT_CYC = STARTUP_UNIT_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    localparam logic [3:0] ADDR_CAUSE = 4'h0;
    localparam logic [3:0] ADDR_POWER_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    localparam int FLAG_POWER_ON = 0;
    localparam int FLAG_PIN = 1;
    localparam int FLAG_BROWNOUT = 2;
    localparam int FLAG_WATCHDOG = 3;
    localparam int FLAG_SCAN = 4;
    localparam int SCAN_DISABLE_BIT = 7;

    localparam int CTRL_SLEEP_MODE_LSB = 0;
    localparam int CTRL_SLEEP_ACTIVE = 3;
    localparam int CTRL_ADC_ENABLE = 4;
    localparam int CTRL_COMP_ENABLE = 5;
    localparam int CTRL_COMP_USES_REF = 6;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SLEEP_IDLE = 3'h0,
        SLEEP_ADC_QUIET = 3'h1,
        SLEEP_POWER_DOWN = 3'h2,
        SLEEP_POWER_SAVE = 3'h3,
        SLEEP_STANDBY = 3'h6,
        SLEEP_EXT_STANDBY = 3'h7
    } rpc_sleep_e;

    // Fuse inputs, each high when programmed
    typedef struct packed {
        logic brownoutEnable;
        logic brownoutLevel;
        logic [3:0] clockSelect;
        logic debugEnable;
        logic scanPortEnable;
    } rpc_fuses_s;

    // Power gating outputs toward the analog and clock blocks
    typedef struct packed {
        logic brownoutDetEnable;
        logic brownoutLevelHigh;
        logic refEnable;
        logic adcEnable;
        logic compEnable;
        logic mainClockRun;
        logic watchdogRun;
    } rpc_power_s;
endpackage

// [rpc_reset_power.sv]
// Reset merging, start-up stretching, cause flags and sleep power gating
`timescale 1ns/1ps
// How it works
// - I/O registers held in reset, then vector fetch
// - Port reset follows each source without clock, except watchdog via its registered pulse
// - Delay counter stretches reset, length from fuses
// - Five reset sources merged, any one resets
// - Power-on low reasserts reset at once
// - Pin low beyond minimum width resets
// - Pin release starts delay before reset release
// - Watchdog reset only when enabled and expired
// - Watchdog pulse one cycle, delay after it
// - Scan reset bit holds reset while set
// - Brown-out enable from fuse only, all modes
// - Level fuse selects 2.7V or 4.0V trip
// - Brown-out asserts at once, releases after delay
// - Enabled watchdog keeps running in sleep
// - Converter stays on; re-enable gives extended conversion
// - Comparator off in deep sleep; ref use persists
// - Reference on when any user needs it
// - Deep sleep disables input buffers except wake pins
// - Debug fuse keeps main clock in power-down/save while the scan port is enabled
// - Scan port off by disable bit or fuse
// - Test output tri-stated unless tap shifting
// - Per-source cause flags, zero-write clear, power-on rules
module rpc_reset_power #(
    parameter int PIN_COUNT = 32,
    parameter int STARTUP_CYC = rpc_pkg::STARTUP_UNIT_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic powerOnLow,
    input wire logic extResetN,
    input wire logic watchdogTimeout,
    input wire logic watchdogEnable,
    input wire logic brownoutLow,
    input wire logic scanResetBit,
    input wire rpc_pkg::rpc_fuses_s fuses,
    input wire logic adcConvStart,
    input wire logic [PIN_COUNT-1:0] wakePinMask,
    input wire logic tapShifting,
    input wire logic tdoData,
    output logic portResetAsync,
    output logic ioRegReset_q,
    output logic vectorFetch_q,
    output rpc_pkg::rpc_power_s power_q,
    output logic adcExtendedNext_q,
    output logic [PIN_COUNT-1:0] inputBufEnable_q,
    output logic scanEnabled,
    output logic tdoOut,
    output logic tdoOe
);
    logic [rpc_pkg::CNT_W-1:0] delayCnt_q;
    logic [rpc_pkg::CNT_W-1:0] delayTarget;
    logic [7:0] pinLowCnt_q;
    logic pinReset;
    logic wdPulse_q;
    logic wdTimeoutPrev_q;
    logic bodActive;
    logic sourceActive;
    logic [4:0] causeFlags_q;
    logic scanDisable_q;
    logic [6:0] powerCtrl_q;
    logic adcPrev_q;
    logic deepSleep;
    logic clocksStopped;
    logic sleeping;
    rpc_pkg::rpc_sleep_e sleepMode;
    logic awHave_q;
    logic wHave_q;
    logic [3:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic doWrite;
    logic causeWrite;
    logic ctrlWrite;

    // Reset merging
    assign bodActive = fuses.brownoutEnable && brownoutLow;
    // Gated by the live pin so the cause ends with the low level
    assign pinReset = !extResetN && (pinLowCnt_q >= 8'(rpc_pkg::PIN_MIN_CYC));
    assign sourceActive = powerOnLow || pinReset || wdPulse_q
        || bodActive || scanResetBit;
    // Pin reset acts here with no clock edge needed
    assign portResetAsync = powerOnLow || !extResetN || wdPulse_q
        || bodActive || scanResetBit;
    assign delayTarget = rpc_pkg::CNT_W'(STARTUP_CYC << fuses.clockSelect[1:0]);

    always_ff @(posedge clk)
    begin
        if (srst || extResetN)
            pinLowCnt_q <= 8'h00;
        else if (!pinReset)
            pinLowCnt_q <= pinLowCnt_q + 8'h01;
    end

    // One-cycle watchdog pulse on a fresh timeout
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wdPulse_q <= 1'b0;
            wdTimeoutPrev_q <= 1'b0;
        end
        else
        begin
            wdTimeoutPrev_q <= watchdogTimeout;
            wdPulse_q <= watchdogEnable && watchdogTimeout && !wdTimeoutPrev_q;
        end
    end

    // Delay counter; counting begins once every source is quiet
    always_ff @(posedge clk)
    begin
        if (srst || sourceActive)
        begin
            delayCnt_q <= '0;
            ioRegReset_q <= 1'b1;
            vectorFetch_q <= 1'b0;
        end
        else if (ioRegReset_q)
        begin
            vectorFetch_q <= 1'b0;
            if (delayCnt_q >= delayTarget - rpc_pkg::CNT_W'(1))
            begin
                ioRegReset_q <= 1'b0;
                vectorFetch_q <= 1'b1;
            end
            else
                delayCnt_q <= delayCnt_q + rpc_pkg::CNT_W'(1);
        end
        else
            vectorFetch_q <= 1'b0;
    end

    // Cause flags; a setting source wins over a zero write
    always_ff @(posedge clk)
    begin
        if (srst)
            causeFlags_q <= 5'h01;
        else
        begin
            if (powerOnLow)
                causeFlags_q[rpc_pkg::FLAG_POWER_ON] <= 1'b1;
            else if (causeWrite && !wData_q[rpc_pkg::FLAG_POWER_ON])
                causeFlags_q[rpc_pkg::FLAG_POWER_ON] <= 1'b0;
            for (int i = 1; i < 5; i++)
            begin
                if (powerOnLow)
                    causeFlags_q[i] <= 1'b0;
                else if ((i == rpc_pkg::FLAG_PIN && pinReset)
                    || (i == rpc_pkg::FLAG_BROWNOUT && bodActive)
                    || (i == rpc_pkg::FLAG_WATCHDOG && wdPulse_q)
                    || (i == rpc_pkg::FLAG_SCAN && scanResetBit))
                    causeFlags_q[i] <= 1'b1;
                else if (causeWrite && !wData_q[i])
                    causeFlags_q[i] <= 1'b0;
            end
        end
    end

    // Software-written state is I/O register state, cleared by internal reset
    always_ff @(posedge clk)
    begin
        if (srst || ioRegReset_q)
        begin
            scanDisable_q <= 1'b0;
            powerCtrl_q <= rpc_pkg::CTRL_RESET;
        end
        else
        begin
            if (causeWrite)
                scanDisable_q <= wData_q[rpc_pkg::SCAN_DISABLE_BIT];
            if (ctrlWrite)
                powerCtrl_q <= wData_q[6:0];
        end
    end

    // Power gating
    assign sleepMode = rpc_pkg::rpc_sleep_e'(powerCtrl_q[rpc_pkg::CTRL_SLEEP_MODE_LSB +: 3]);
    assign sleeping = powerCtrl_q[rpc_pkg::CTRL_SLEEP_ACTIVE];
    assign deepSleep = sleeping && (sleepMode == rpc_pkg::SLEEP_POWER_DOWN
        || sleepMode == rpc_pkg::SLEEP_POWER_SAVE);
    // Both I/O and converter clocks stop in every mode past noise reduction
    assign clocksStopped = sleeping && sleepMode != rpc_pkg::SLEEP_IDLE
        && sleepMode != rpc_pkg::SLEEP_ADC_QUIET;
    assign scanEnabled = fuses.scanPortEnable && !scanDisable_q;
    assign tdoOe = scanEnabled && tapShifting;
    assign tdoOut = tdoOe && tdoData;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            power_q <= '0;
            inputBufEnable_q <= '1;
            adcExtendedNext_q <= 1'b1;
            adcPrev_q <= 1'b0;
        end
        else
        begin
            power_q.brownoutDetEnable <= fuses.brownoutEnable;
            power_q.brownoutLevelHigh <= fuses.brownoutLevel;
            power_q.refEnable <= fuses.brownoutEnable
                || (powerCtrl_q[rpc_pkg::CTRL_COMP_ENABLE]
                && powerCtrl_q[rpc_pkg::CTRL_COMP_USES_REF])
                || powerCtrl_q[rpc_pkg::CTRL_ADC_ENABLE];
            power_q.adcEnable <= powerCtrl_q[rpc_pkg::CTRL_ADC_ENABLE];
            power_q.compEnable <= powerCtrl_q[rpc_pkg::CTRL_COMP_ENABLE]
                && !clocksStopped;
            power_q.mainClockRun <= !deepSleep
                || (fuses.debugEnable && scanEnabled);
            power_q.watchdogRun <= watchdogEnable;
            inputBufEnable_q <= clocksStopped ? wakePinMask : '1;
            adcPrev_q <= powerCtrl_q[rpc_pkg::CTRL_ADC_ENABLE];
            if (powerCtrl_q[rpc_pkg::CTRL_ADC_ENABLE] && !adcPrev_q)
                adcExtendedNext_q <= 1'b1;
            else if (adcConvStart)
                adcExtendedNext_q <= 1'b0;
        end
    end

    // Register bus slave
    assign s_axi_awready = !awHave_q && !s_axi_bvalid;
    assign s_axi_wready = !wHave_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
    assign causeWrite = doWrite && awAddr_q == rpc_pkg::ADDR_CAUSE && wStrb_q[0];
    assign ctrlWrite = doWrite && awAddr_q == rpc_pkg::ADDR_POWER_CTRL && wStrb_q[0];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awAddr_q <= 4'h0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rpc_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == rpc_pkg::ADDR_CAUSE || awAddr_q == rpc_pkg::ADDR_POWER_CTRL)
                    s_axi_bresp <= rpc_pkg::RESP_OKAY;
                else
                    s_axi_bresp <= rpc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= rpc_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= rpc_pkg::RESP_OKAY;
            if (s_axi_araddr == rpc_pkg::ADDR_CAUSE)
                s_axi_rdata <= {24'h0, scanDisable_q, 2'h0, causeFlags_q};
            else if (s_axi_araddr == rpc_pkg::ADDR_POWER_CTRL)
                s_axi_rdata <= {25'h0, powerCtrl_q};
            else if (s_axi_araddr == rpc_pkg::ADDR_STATUS)
                s_axi_rdata <= {22'h0, scanEnabled, adcExtendedNext_q, power_q,
                    ioRegReset_q};
            else
            begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= rpc_pkg::RESP_SLVERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    port_reset_a: assert property (
        (powerOnLow || !extResetN || scanResetBit) |-> portResetAsync)
        else $error("port reset missed an active source");
    source_immediate_a: assert property (sourceActive |=> ioRegReset_q && delayCnt_q == 0)
        else $error("reset not reasserted at once or counter not restarted");
    hold_until_count_a: assert property (
        (ioRegReset_q && !sourceActive && delayCnt_q < delayTarget - 1 && $stable(delayTarget))
        |=> ioRegReset_q)
        else $error("internal reset released before the delay count");
    wd_gate_a: assert property (wdPulse_q |-> $past(watchdogEnable && watchdogTimeout))
        else $error("watchdog pulse without an enabled timeout");
    wd_pulse_a: assert property (wdPulse_q |=> !wdPulse_q)
        else $error("watchdog pulse longer than one cycle");
    pin_width_a: assert property (pinReset |-> !extResetN && $past(!extResetN, 2))
        else $error("pin reset without a held low level");
    scan_hold_a: assert property (scanResetBit[*2] |=> ioRegReset_q)
        else $error("scan reset bit did not hold reset");
    flag_set_a: assert property ((wdPulse_q && !powerOnLow) |=> causeFlags_q[rpc_pkg::FLAG_WATCHDOG])
        else $error("watchdog cause flag not set");
    fetch_on_release_a: assert property ($fell(ioRegReset_q) |-> vectorFetch_q)
        else $error("no vector fetch on reset release");
    tdo_tristate_a: assert property (!tapShifting |-> !tdoOe)
        else $error("test output driven outside shifting");
    deep_buffers_a: assert property (clocksStopped |=> inputBufEnable_q == $past(wakePinMask))
        else $error("input buffers not gated in deep sleep");
    debug_clock_a: assert property (
        (fuses.debugEnable && scanEnabled) |=> power_q.mainClockRun)
        else $error("main clock stopped with debug enabled");
    pin_follow_a: assert property (extResetN |-> !pinReset)
        else $error("pin reset outlived the pin low level");
    vector_pulse_a: assert property (vectorFetch_q |=> !vectorFetch_q)
        else $error("vector fetch longer than one cycle");
    scan_off_a: assert property ((!fuses.scanPortEnable || scanDisable_q) |-> !scanEnabled)
        else $error("scan port enabled while disabled");

    // Power gating checks
    comp_sleep_a: assert property (clocksStopped |=> !power_q.compEnable)
        else $error("comparator left on in deep sleep");
    bod_ref_a: assert property (fuses.brownoutEnable |=> power_q.refEnable)
        else $error("reference off while brown-out needs it");
    bod_fuse_a: assert property (
        1'b1 |=> power_q.brownoutDetEnable == $past(fuses.brownoutEnable))
        else $error("brown-out enable not taken from its fuse");
    wd_run_a: assert property (watchdogEnable |=> power_q.watchdogRun)
        else $error("enabled watchdog stopped");

    wd_release_c: cover property (wdPulse_q ##[1:1000] $fell(ioRegReset_q));
    pin_reset_c: cover property ($rose(pinReset) ##[1:200] extResetN);
    cause_clear_c: cover property (causeWrite ##1 causeFlags_q == 5'h00);
    restart_c: cover property (ioRegReset_q && delayCnt_q != 0 ##1 delayCnt_q == 0);
    deep_sleep_c: cover property (clocksStopped ##2 inputBufEnable_q != '1);
endmodule // rpc_reset_power

// [rpc_source_model.sv]
// Far-side model of the five reset sources
`timescale 1ns/1ps
module rpc_source_model (
    input wire logic clk,
    output logic powerOnLow,
    output logic extResetN,
    output logic watchdogTimeout,
    output logic brownoutLow,
    output logic scanResetBit
);
    initial
    begin
        powerOnLow = 1'b0;
        extResetN = 1'b1;
        watchdogTimeout = 1'b0;
        brownoutLow = 1'b0;
        scanResetBit = 1'b0;
    end

    // Puts one source active or idle just after an edge
    task automatic set(input int idx, input logic on);
        @(posedge clk);
        case (idx)
            0: powerOnLow <= on;
            1: extResetN <= !on;
            2: brownoutLow <= on;
            3: watchdogTimeout <= on;
            default: scanResetBit <= on;
        endcase
    endtask
endmodule // rpc_source_model
